// ===== rtl/line_diag_pkg.sv
// package of constants shared by the line diagnosis port controller
package line_diag_pkg;

   // local addresses decoded from the frame identifier
   localparam logic [2:0] addr_cmd_write    = 3'h0;
   localparam logic [2:0] addr_status_read  = 3'h1;
   localparam logic [2:0] addr_a_write      = 3'h2;
   localparam logic [2:0] addr_a_read       = 3'h3;
   localparam logic [2:0] addr_ab_write     = 3'h4;
   localparam logic [2:0] addr_ab_read      = 3'h5;
   localparam logic [2:0] addr_b_write      = 3'h6;
   localparam logic [2:0] addr_b_read       = 3'h7;

   // accepted data byte counts
   localparam logic [2:0] len_one           = 3'h1;
   localparam logic [2:0] len_two           = 3'h2;
   localparam logic [2:0] len_three         = 3'h3;
   localparam logic [2:0] len_ab            = 3'h6;

   // command register field positions and select codes
   localparam int         cmd_sel_lsb       = 0;
   localparam int         cmd_surv_pos      = 3;
   localparam int         cmd_owner_lsb     = 4;
   localparam int         cmd_lock_pos      = 7;
   localparam logic [2:0] sel_transparent   = 3'h3;
   localparam logic [2:0] sel_forced_triple = 3'h7;

   // status register field positions
   localparam int         stat_agree_pos    = 2;
   localparam int         stat_safety_pos   = 3;

   // values after reset, and the all-output direction byte
   localparam logic [7:0] cmd_reset         = 8'h00;
   localparam logic [7:0] ddr_reset         = 8'h00;
   localparam logic [7:0] data_reset        = 8'h00;
   localparam logic [7:0] opt_reset         = 8'h00;
   localparam logic [7:0] all_output        = 8'hff;

   // level that marks a dominant bus bit on the selected line
   localparam logic       dominant_level    = 1'b0;

   // timing: base period and safety clock rate
   localparam int         base_period_ms    = 1000;
   localparam int         safety_clk_khz    = 500;
   localparam int         base_ticks        = base_period_ms * safety_clk_khz;
   localparam int         short_div         = 16;
   localparam int         medium_div        = 4;
   localparam int         super_mult        = 4;
   localparam int         tick_width        = 24;

   // receive line selection
   typedef enum logic [1:0] {
      line_diff = 2'b00,
      line_true = 2'b01,
      line_comp = 2'b10
   } line_sel_type;

endpackage : line_diag_pkg

// ===== rtl/level_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module level_sync #(
   parameter int          width = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [width-1:0] din,
   output logic      [width-1:0] dout
);
   logic [width-1:0] meta_ff;    // first stage, read only by second
   logic [width-1:0] dout_ff;    // second stage, safe to use

   // pins are asynchronous to clk, so two stages before any logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         dout_ff <= '0;
      end else begin
         meta_ff <= din;
         dout_ff <= meta_ff;
      end
   end

   assign dout = dout_ff;
endmodule : level_sync

// ===== rtl/tick_timeout.sv
// timeout counter on safety clock ticks with restart and expiry pulse
`timescale 1ns/10ps
module tick_timeout (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  tick,
   input  wire logic                                  restart,
   input  wire logic [line_diag_pkg::tick_width-1:0]  limit,
   output logic                                       expired
);
   logic [line_diag_pkg::tick_width-1:0] count_ff;  // ticks since restart
   logic                                 expired_ff; // one-cycle pulse

   // restart has priority so a qualifying event always resets the wait
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_ff   <= '0;
         expired_ff <= 1'b0;
      end else if (restart) begin
         count_ff   <= '0;
         expired_ff <= 1'b0;
      end else if (tick) begin
         if (count_ff >= limit - 1'b1) begin
            // rearm so a persisting fault fires once per period
            count_ff   <= '0;
            expired_ff <= 1'b1;
         end else begin
            count_ff   <= count_ff + 1'b1;
            expired_ff <= 1'b0;
         end
      end else begin
         expired_ff <= 1'b0;
      end
   end

   assign expired = expired_ff;
endmodule : tick_timeout

// ===== rtl/line_diagnosis_safety_port_ctl.sv
// control core: port config, line selection, timeouts and safety mode
`timescale 1ns/10ps
module line_diagnosis_safety_port_ctl #(
   parameter int base_ticks = line_diag_pkg::base_ticks  // ticks per T
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   // receive lines from the transceiver comparators
   input  wire logic       rx_differential_line,
   input  wire logic       rx_true_line,
   input  wire logic       rx_complement_line,
   input  wire logic       safety_clock_pin,
   // frame decoder results, same clock domain
   input  wire logic       coherent_frame,
   input  wire logic       frame_done,
   input  wire logic [2:0] frame_local_addr,
   input  wire logic [2:0] frame_len,
   input  wire logic [7:0] frame_byte0,
   input  wire logic [7:0] frame_byte1,
   input  wire logic [7:0] frame_byte2,
   input  wire logic [7:0] frame_byte3,
   input  wire logic [7:0] frame_byte4,
   input  wire logic [7:0] frame_byte5,
   output logic            frame_ack,
   output logic            rx_selected,
   // read back values for the frame encoder
   output logic [7:0]      line_and_lock_status,
   output logic [7:0]      first_port_value,
   output logic [7:0]      second_port_value,
   // port pins split into input, output and enable
   input  wire logic [7:0] first_port_pins_in,
   output logic [7:0]      first_port_pins_out,
   output logic [7:0]      first_port_pins_oe,
   input  wire logic [7:0] second_port_pins_in,
   output logic [7:0]      second_port_pins_out,
   output logic [7:0]      second_port_pins_oe,
   output logic            alert
);

   // derived limits keep fixed ratios to the base period
   localparam int tw = line_diag_pkg::tick_width;
   localparam logic [tw-1:0] short_lim  =
      tw'(base_ticks / line_diag_pkg::short_div);
   localparam logic [tw-1:0] medium_lim =
      tw'(base_ticks / line_diag_pkg::medium_div);
   localparam logic [tw-1:0] long_lim   = tw'(base_ticks);
   localparam logic [tw-1:0] super_lim  =
      tw'(base_ticks * line_diag_pkg::super_mult);

   // accepted write frame for a given local address and byte count
   function automatic logic write_ok(input logic [2:0] addr,
                                     input logic [2:0] len);
      begin
         case (addr)
            line_diag_pkg::addr_cmd_write:
               write_ok = (len == line_diag_pkg::len_one);
            line_diag_pkg::addr_a_write,
            line_diag_pkg::addr_b_write:
               write_ok = (len == line_diag_pkg::len_one) ||
                          (len == line_diag_pkg::len_two) ||
                          (len == line_diag_pkg::len_three);
            line_diag_pkg::addr_ab_write:
               write_ok = (len == line_diag_pkg::len_ab);
            default:
               write_ok = 1'b1;  // reads carry no data bytes to check
         endcase
      end
   endfunction : write_ok

   // next direction byte for a short port write
   function automatic logic [7:0] pick_ddr(input logic [2:0] len,
                                           input logic [7:0] given);
      begin
         // one byte makes the whole port an output
         pick_ddr = (len == line_diag_pkg::len_one) ?
                    line_diag_pkg::all_output : given;
      end
   endfunction : pick_ddr

   // next option byte for a short port write
   function automatic logic [7:0] pick_opt(input logic [2:0] len,
                                           input logic [7:0] given,
                                           input logic [7:0] prev);
      begin
         if (len == line_diag_pkg::len_three) begin
            pick_opt = given;
         end else if (len == line_diag_pkg::len_one) begin
            pick_opt = line_diag_pkg::opt_reset;
         end else begin
            pick_opt = prev;
         end
      end
   endfunction : pick_opt

   logic [2:0]  rx_sync;          // synchronised receive lines
   logic        safety_clk_sync;  // synchronised safety clock
   logic        safety_clk_d_ff;  // previous safety clock level
   logic        tick;             // one cycle per safety clock rise
   logic [15:0] pins_sync;        // synchronised port pins
   logic        agree;            // all three lines equal
   logic        bus_dominant;     // selected line is dominant
   logic        accepted;         // addressed frame that is honoured
   logic        cmd_write;        // command register write
   logic        a_write;          // port A written in this frame
   logic        b_write;          // port B written in this frame
   logic        short_exp;        // short timeout pulse
   logic        medium_exp;       // medium timeout pulse
   logic        long_exp;         // long timeout pulse
   logic        super_exp;        // super-long timeout pulse
   logic        step_line;        // automatic mode moves to next line
   logic        enter_safety;     // condition to enter safety mode

   logic [7:0]  cmd_ff;           // line_and_lock_command
   logic [7:0]  nxt_cmd;
   line_diag_pkg::line_sel_type line_ff;     // selected receive line
   line_diag_pkg::line_sel_type nxt_line;
   logic        forced_ff;        // selection held despite timeouts
   logic        triple_ff;        // differential qualified by agreement
   logic        rx_hold_ff;       // last agreed level in triple mode
   logic        safety_ff;        // safety mode
   logic        accessed_ff;      // any access since reset
   logic        alert_ff;
   logic        ack_ff;
   logic [7:0]  data_a_ff;
   logic [7:0]  ddr_a_ff;
   logic [7:0]  opt_a_ff;
   logic [7:0]  data_b_ff;
   logic [7:0]  ddr_b_ff;
   logic [7:0]  opt_b_ff;
   logic [7:0]  status_ff;
   logic [7:0]  val_a_ff;
   logic [7:0]  val_b_ff;

   // all pin inputs pass two flip-flops before use
   level_sync #(.width(3)) u_rx_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({rx_complement_line, rx_true_line, rx_differential_line}),
      .dout (rx_sync)
   );

   level_sync #(.width(1)) u_clk_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  (safety_clock_pin),
      .dout (safety_clk_sync)
   );

   level_sync #(.width(16)) u_pin_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({second_port_pins_in, first_port_pins_in}),
      .dout (pins_sync)
   );

   // rising edge of the slow safety clock gives the timeout tick
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         safety_clk_d_ff <= 1'b0;
      end else begin
         safety_clk_d_ff <= safety_clk_sync;
      end
   end

   assign tick = safety_clk_sync & ~safety_clk_d_ff;

   // triple sampling: all high or all low
   assign agree = (&rx_sync) | ~(|rx_sync);

   // receive line mux; triple mode keeps the last agreed level
   always_comb begin
      if (triple_ff) begin
         rx_selected = agree ? rx_sync[0] : rx_hold_ff;
      end else begin
         case (line_ff)
            line_diag_pkg::line_true: rx_selected = rx_sync[1];
            line_diag_pkg::line_comp: rx_selected = rx_sync[2];
            default:                  rx_selected = rx_sync[0];
         endcase
      end
   end

   // hold register for the triple-qualified level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_hold_ff <= 1'b1;
      end else if (agree) begin
         rx_hold_ff <= rx_sync[0];
      end
   end

   assign bus_dominant = (rx_selected == line_diag_pkg::dominant_level);

   // frame decode: bad lengths are neither acked nor applied
   assign accepted  = frame_done & write_ok(frame_local_addr, frame_len);
   assign cmd_write = accepted &
                      (frame_local_addr == line_diag_pkg::addr_cmd_write);
   assign a_write   = accepted &
                      ((frame_local_addr == line_diag_pkg::addr_a_write) |
                       (frame_local_addr == line_diag_pkg::addr_ab_write));
   assign b_write   = accepted &
                      ((frame_local_addr == line_diag_pkg::addr_b_write) |
                       (frame_local_addr == line_diag_pkg::addr_ab_write));

   // four timeouts restarted by bus events; long and super-long share one restart
   tick_timeout u_short (
      .clk     (clk),
      .rstn    (rstn),
      .tick    (tick),
      .restart (~bus_dominant),
      .limit   (short_lim),
      .expired (short_exp)
   );

   tick_timeout u_medium (
      .clk     (clk),
      .rstn    (rstn),
      .tick    (tick),
      .restart (coherent_frame),
      .limit   (medium_lim),
      .expired (medium_exp)
   );

   tick_timeout u_long (
      .clk     (clk),
      .rstn    (rstn),
      .tick    (tick),
      .restart (accepted),
      .limit   (long_lim),
      .expired (long_exp)
   );

   tick_timeout u_super (
      .clk     (clk),
      .rstn    (rstn),
      .tick    (tick),
      .restart (accepted),
      .limit   (super_lim),
      .expired (super_exp)
   );

   // line faults step the automatic selection to the next line
   assign step_line = ~forced_ff & (short_exp | medium_exp);

   // command write: upper bits always, low bits unless transparent
   always_comb begin
      nxt_cmd  = cmd_ff;
      nxt_line = line_ff;
      if (cmd_write) begin
         nxt_cmd[7:3] = frame_byte0[7:3];
         if (frame_byte0[2:0] != line_diag_pkg::sel_transparent) begin
            nxt_cmd[2:0] = frame_byte0[2:0];
            // code 11 has no line, so 111 falls back to differential
            nxt_line = (frame_byte0[1:0] == 2'b11) ?
                       line_diag_pkg::line_diff :
                       line_diag_pkg::line_sel_type'(frame_byte0[1:0]);
         end
      end else if (step_line) begin
         case (line_ff)
            line_diag_pkg::line_diff: nxt_line = line_diag_pkg::line_true;
            line_diag_pkg::line_true: nxt_line = line_diag_pkg::line_comp;
            default:                  nxt_line = line_diag_pkg::line_diff;
         endcase
      end
   end

   // command register and line selection state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_ff    <= line_diag_pkg::cmd_reset;
         line_ff   <= line_diag_pkg::line_diff;
         forced_ff <= 1'b0;
         triple_ff <= 1'b0;
      end else begin
         cmd_ff    <= nxt_cmd;
         line_ff   <= nxt_line;
         forced_ff <= nxt_cmd[2];
         triple_ff <= (nxt_cmd[2:0] == line_diag_pkg::sel_forced_triple);
      end
   end

   // remember whether any access has happened since reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         accessed_ff <= 1'b0;
      end else if (accepted) begin
         accessed_ff <= 1'b1;
      end
   end

   // surveillance decides entry; super-long before first access only
   assign enter_safety = ~cmd_ff[line_diag_pkg::cmd_surv_pos] &
                         ((super_exp & ~accessed_ff) |
                          (long_exp & accessed_ff));

   // safety mode: entry wins over a port A write in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         safety_ff <= 1'b0;
      end else if (enter_safety) begin
         safety_ff <= 1'b1;
      end else if (a_write) begin
         safety_ff <= 1'b0;
      end
   end

   // alert follows safety, or pulses per frame when inhibited
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         alert_ff <= 1'b0;
      end else if (cmd_ff[line_diag_pkg::cmd_surv_pos]) begin
         alert_ff <= frame_done;
      end else begin
         alert_ff <= enter_safety | (safety_ff & ~a_write);
      end
   end

   // port A registers; safety entry floats the port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_a_ff <= line_diag_pkg::data_reset;
         ddr_a_ff  <= line_diag_pkg::ddr_reset;
         opt_a_ff  <= line_diag_pkg::opt_reset;
      end else if (enter_safety) begin
         ddr_a_ff  <= line_diag_pkg::ddr_reset;
      end else if (a_write) begin
         data_a_ff <= frame_byte0;
         if (frame_local_addr == line_diag_pkg::addr_ab_write) begin
            ddr_a_ff <= frame_byte1;
            opt_a_ff <= frame_byte2;
         end else begin
            ddr_a_ff <= pick_ddr(frame_len, frame_byte1);
            opt_a_ff <= pick_opt(frame_len, frame_byte2, opt_a_ff);
         end
      end
   end

   // port B registers; safety leaves them as they are
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_b_ff <= line_diag_pkg::data_reset;
         ddr_b_ff  <= line_diag_pkg::ddr_reset;
         opt_b_ff  <= line_diag_pkg::opt_reset;
      end else if (b_write) begin
         if (frame_local_addr == line_diag_pkg::addr_ab_write) begin
            data_b_ff <= frame_byte3;
            ddr_b_ff  <= frame_byte4;
            opt_b_ff  <= frame_byte5;
         end else begin
            data_b_ff <= frame_byte0;
            ddr_b_ff  <= pick_ddr(frame_len, frame_byte1);
            opt_b_ff  <= pick_opt(frame_len, frame_byte2, opt_b_ff);
         end
      end
   end

   // status and pin read-back registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_ff <= 8'h00;
         val_a_ff  <= 8'h00;
         val_b_ff  <= 8'h00;
      end else begin
         status_ff[7:4] <= cmd_ff[7:4];
         status_ff[line_diag_pkg::stat_safety_pos] <= safety_ff;
         status_ff[line_diag_pkg::stat_agree_pos]  <= agree;
         status_ff[1:0] <= line_ff;
         val_a_ff  <= pins_sync[7:0];
         val_b_ff  <= pins_sync[15:8];
      end
   end

   // acknowledge only frames with a legal byte count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= accepted;
      end
   end

   // an option bit of 1 is illegal; it only disables the driver
   assign first_port_pins_out  = data_a_ff;
   assign first_port_pins_oe   = ddr_a_ff & ~opt_a_ff;
   assign second_port_pins_out = data_b_ff;
   assign second_port_pins_oe  = ddr_b_ff & ~opt_b_ff;

   assign line_and_lock_status = status_ff;
   assign first_port_value     = val_a_ff;
   assign second_port_value    = val_b_ff;
   assign frame_ack            = ack_ff;
   assign alert                = alert_ff;

endmodule : line_diagnosis_safety_port_ctl

// ===== verif/line_diag_monitor.sv
// concurrent checks on the port controller pins
`timescale 1ns/10ps
module line_diag_monitor (
   input wire logic       clk, rstn, frame_done, frame_ack, alert,
   input wire logic       rx_differential_line, rx_true_line,
   input wire logic       rx_complement_line,
   input wire logic [2:0] frame_local_addr, frame_len,
   input wire logic [7:0] frame_byte0, line_and_lock_status,
   input wire logic [7:0] first_port_pins_oe, first_port_pins_out,
   input wire logic [7:0] second_port_pins_oe, second_port_pins_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // all three receive levels agree
   wire same = rx_differential_line == rx_true_line &&
               rx_true_line == rx_complement_line;
   sequence s_wr; frame_done && frame_local_addr == 3'h2; endsequence
   sequence s_safe; $rose(line_and_lock_status[3]); endsequence
   a_ack_legal: assert property (
      (s_wr ##0 frame_len inside {[1:3]}) |=> frame_ack) else $error("no ack");
   a_bad_len: assert property (
      (s_wr ##0 frame_len > 3'h3) |=> !frame_ack) else $error("bad ack");
   a_one_byte: assert property ((s_wr ##0 frame_len == 3'h1) |=>
      first_port_pins_oe == 8'hff && first_port_pins_out == $past(frame_byte0))
      else $error("one byte write wrong");
   a_reset_float: assert property ($rose(rstn) |-> !alert &&
      first_port_pins_oe == 8'h00 && second_port_pins_oe == 8'h00)
      else $error("not floating after reset");
   a_safe_port_a: assert property (s_safe |->
      first_port_pins_oe == 8'h00 && alert) else $error("safety entry wrong");
   a_port_b_hold: assert property (s_safe |->
      $stable(second_port_pins_oe) && $stable(second_port_pins_out))
      else $error("port b moved");
   // only a write of legal length is honoured, so only it ends safety
   a_exit_write: assert property (
      (s_wr ##0 frame_len inside {[1:3]} ##0 line_and_lock_status[3])
      |=> !alert ##1 !line_and_lock_status[3]) else $error("no safety exit");
   a_agree_bit: assert property (
      same [*4] |-> line_and_lock_status[2]) else $error("agree bit low");
   a_cmd_mirror: assert property (frame_done && frame_len == 3'h1 &&
      frame_local_addr == 3'h0 |=> ##1 line_and_lock_status[7:4] ==
      $past(frame_byte0[7:4], 2)) else $error("lock not mirrored");
endmodule : line_diag_monitor
bind line_diagnosis_safety_port_ctl line_diag_monitor mon (.clk, .rstn,
   .frame_done, .frame_ack, .alert, .rx_differential_line, .rx_true_line,
   .rx_complement_line, .frame_local_addr, .frame_len, .frame_byte0,
   .line_and_lock_status, .first_port_pins_oe, .first_port_pins_out,
   .second_port_pins_oe, .second_port_pins_out);

// ===== verif/line_rx_partner.sv
// far side model: transceiver comparator outputs and safety oscillator
`timescale 1ns/10ps
module line_rx_partner (
   input  wire logic split,                // force the true line apart
   output logic      rx_differential_line,
   output logic      rx_true_line,
   output logic      rx_complement_line,
   output logic      safety_clock_pin      // free running 500 kHz
);
   initial safety_clock_pin = 1'b0;
   always #1000 safety_clock_pin = ~safety_clock_pin;
   // idle bus stays recessive so the short timeout never fires
   assign rx_differential_line = 1'b1;
   assign rx_true_line         = ~split;
   assign rx_complement_line   = 1'b1;
endmodule : line_rx_partner

// ===== verif/tb_line_diagnosis_safety_port_ctl.sv
// self-checking bench for the line diagnosis port controller
`timescale 1ns/10ps
module tb_line_diagnosis_safety_port_ctl;
   logic       clk = 1'b0, rstn = 1'b0, frame_done = 1'b0, split = 1'b0;
   logic [2:0] frame_local_addr = 3'h0, frame_len = 3'h0;
   logic [7:0] frame_byte0 = 8'h00, frame_byte1 = 8'h00;
   logic       frame_ack, alert, safety_clock_pin;
   logic       rx_differential_line, rx_true_line, rx_complement_line;
   logic       rx_selected;
   logic [7:0] first_port_value, second_port_value;
   logic [7:0] line_and_lock_status, first_port_pins_out, first_port_pins_oe;
   logic [7:0] second_port_pins_out, second_port_pins_oe;
   int         fails = 0, comparisons = 0;
   always #4 clk = ~clk;
   line_rx_partner far (.split, .rx_differential_line, .rx_true_line,
      .rx_complement_line, .safety_clock_pin);
   // 16 ticks per base period keeps even the super-long timeout short
   line_diagnosis_safety_port_ctl #(.base_ticks(16)) dut (.clk, .rstn,
      .rx_differential_line, .rx_true_line, .rx_complement_line,
      .safety_clock_pin, .coherent_frame(frame_done), .frame_done,
      .frame_local_addr, .frame_len, .frame_byte0, .frame_byte1,
      .frame_byte2(8'h00), .frame_byte3(8'h00), .frame_byte4(8'h00),
      .frame_byte5(8'h00), .frame_ack, .rx_selected,
      .line_and_lock_status, .first_port_value, .second_port_value,
      .first_port_pins_in(first_port_pins_out), .first_port_pins_out,
      .first_port_pins_oe, .second_port_pins_in(second_port_pins_out),
      .second_port_pins_out, .second_port_pins_oe, .alert);
   task automatic summarize();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // let updates of the edge land before sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // one frame_done strobe, then the acknowledge of that frame
   task automatic send(input logic [2:0] a, n, input logic [7:0] d0, d1,
                       input logic ack_exp);
      @(posedge clk);
      frame_local_addr <= a;
      frame_len <= n;
      frame_byte0 <= d0;
      frame_byte1 <= d1;
      frame_done <= 1'b1;
      @(posedge clk);
      frame_done <= 1'b0;
      #1;
      chk({7'h0, frame_ack}, {7'h0, ack_exp});
   endtask : send
   task automatic wait_safe(input int lim);
      int i;
      for (i = 0; i < lim && line_and_lock_status[3] !== 1'b1; i++) step(1);
      if (i == lim) begin
         fails++;
         summarize();
      end
   endtask : wait_safe
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      step(2);
      chk(line_and_lock_status & 8'hfb, 8'h00);
      chk(first_port_pins_oe | second_port_pins_oe, {7'h0, alert});
      send(3'h0, 3'h1, 8'hd4, 8'h00, 1'b1);
      step(1);
      chk(line_and_lock_status & 8'hfb, 8'hd0);
      // transparent code keeps the forced line, upper bits still change
      send(3'h0, 3'h1, 8'h2b, 8'h00, 1'b1);
      step(1);
      chk(line_and_lock_status & 8'hfb, 8'h20);
      // surveillance inhibited: alert pulses once per frame
      send(3'h1, 3'h1, 8'h00, 8'h00, 1'b1);
      chk({7'h0, alert}, 8'h01);
      step(1);
      chk({7'h0, alert}, 8'h00);
      send(3'h0, 3'h1, 8'hd4, 8'h00, 1'b1);
      send(3'h2, 3'h3, 8'ha5, 8'h0f, 1'b1);
      chk(first_port_pins_oe, 8'h0f);
      chk(first_port_pins_out & 8'h0f, 8'h05);
      step(3);
      chk(first_port_value, 8'ha5);
      send(3'h2, 3'h4, 8'hff, 8'hff, 1'b0);
      chk(first_port_pins_oe, 8'h0f);
      send(3'h4, 3'h6, 8'h81, 8'hf0, 1'b1);
      chk(first_port_pins_oe | second_port_pins_oe, 8'hf0);
      send(3'h6, 3'h1, 8'h3c, 8'h00, 1'b1);
      chk(second_port_pins_out & second_port_pins_oe, 8'h3c);
      step(3);
      chk(second_port_value, 8'h3c);
      $display("test done: port writes");
      split <= 1'b1;
      step(6);
      chk({7'h0, line_and_lock_status[2]}, 8'h00);
      chk({7'h0, rx_selected}, 8'h01);
      split <= 1'b0;
      step(6);
      chk({7'h0, line_and_lock_status[2]}, 8'h01);
      wait_safe(8000);
      chk({first_port_pins_oe[6:0], alert}, 8'h01);
      chk(second_port_pins_oe, 8'hff);
      send(3'h2, 3'h1, 8'h55, 8'h00, 1'b1);
      chk({first_port_pins_oe[6:0], alert}, 8'hfe);
      $display("test done: safety after access");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      wait_safe(20000);
      chk({7'h0, alert}, 8'h01);
      // sixteen medium expiries step diff-true-comp five times plus one
      chk(line_and_lock_status & 8'h0b, 8'h09);
      $display("test done: safety after reset");
      summarize();
   end
endmodule : tb_line_diagnosis_safety_port_ctl
